// >>> sensor_host_regs_and_timers.v
// Two-wire slave register bank with power, integration, proximity and wait timers
//
// Function
// R1 - Two-wire slave at 7-bit address, both speeds
// R2 - 8-bit pointer increments after every data byte
// R3 - Pointer survives STOP; bare read continues
// R4 - Low byte read latches 16-bit value
// R5 - Host accesses 16-bit fields low then high
// R6 - Write transfer; slave acks ninth clock
// R7 - Read: master acks, ends with nack
// R8 - Power bit runs or stops oscillator
// R9 - Light and proximity need power bit
// R10 - Wait enable bit gates wait timer
// R11 - Same-write light and power runs autozero
// R12 - Host programs fields before enables
// R13 - Integration down counter, terminal count zero
// R14 - Max count grows 1024 per step
// R15 - Oscillator over 11; step 2048 clocks
// R16 - Proximity sample (rate+1) times 88us
// R17 - Wait (value+1) steps, long twelvefold
// R18 - Status flags clear on access
// R19 - Colour results split low then high
// R20 - Factory offset magnitude and sign registers
// R21 - Config bit 2 selects long wait
// R22 - Reset loads defaults, clears pointer
`timescale 1ns/100ps
`include "sensor_defs.vh"

module sensor_host_regs_and_timers #(
    parameter [6:0]  CHIP_ADDR       = 7'h29,
    // Arbitrary identification values
    parameter [7:0]  REVISION_VALUE  = 8'h01,
    parameter [7:0]  PART_VALUE      = 8'h5a,
    parameter [11:0] STEP_INT_CYCLES = `STEP_INT_CYCLES,
    parameter [9:0]  PROX_UNIT_OSC   = `PROX_UNIT_OSC
) (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out_q,
    output reg         sda_oe_n_q,
    input  wire [15:0] clear_data,
    input  wire [15:0] red_data,
    input  wire [15:0] green_data,
    input  wire [15:0] blue_data,
    input  wire [7:0]  prox_data,
    input  wire [4:0]  flag_set,
    output reg  [7:0]  flags_q,
    output reg         osc_on_q,
    output reg         autozero_q,
    output reg         prox_active_q,
    output reg         light_active_q,
    output reg         wait_active_q,
    output reg         prox_done_q,
    output reg         light_done_q,
    output reg  [15:0] light_max_q
);

localparam [7:0] A_EN   = `REG_FUNCTION_ENABLES;
localparam [7:0] A_AT   = `REG_LIGHT_INT_TIME;
localparam [7:0] A_PR   = `REG_PROX_SAMPLE_RATE;
localparam [7:0] A_WT   = `REG_WAIT_TIME;
localparam [7:0] A_C0   = `REG_CONFIG_ZERO;
localparam [7:0] A_C3   = `REG_CONFIG_THREE;
localparam [7:0] A_LLLO = `REG_LT_LOW_LO;
localparam [7:0] A_LHLO = `REG_LT_HIGH_LO;

// Bus states
localparam [6:0] B_IDLE = 7'h01;
localparam [6:0] B_ADDR = 7'h02;
localparam [6:0] B_ACK  = 7'h04;
localparam [6:0] B_REG  = 7'h08;
localparam [6:0] B_WDAT = 7'h10;
localparam [6:0] B_RDAT = 7'h20;
localparam [6:0] B_RACK = 7'h40;

// Measurement states
localparam [4:0] S_IDLE = 5'h01;
localparam [4:0] S_AZ   = 5'h02;
localparam [4:0] S_PROX = 5'h04;
localparam [4:0] S_ALS  = 5'h08;
localparam [4:0] S_WAIT = 5'h10;

////////////////////////////////////////////////////////////////////////////////
// Register helpers

function is_rw;
    input [7:0] a;
    begin
        case (a)
            `REG_FUNCTION_ENABLES, `REG_LIGHT_INT_TIME, `REG_PROX_SAMPLE_RATE, `REG_WAIT_TIME,
            `REG_LT_LOW_LO, `REG_LT_LOW_HI, `REG_LT_HIGH_LO, `REG_LT_HIGH_HI,
            `REG_PROX_LOW_THRESH, `REG_PROX_HIGH_THRESH, `REG_INT_PERSISTENCE, `REG_CONFIG_ZERO,
            `REG_PROX_PULSE_CFG, `REG_PROX_GAIN_CFG, `REG_CONFIG_ONE, `REG_LIGHT_GAIN_CFG,
            `REG_CONFIG_THREE, `REG_PROX_OFFSET_MAG, `REG_PROX_OFFSET_SIGN, `REG_CALIBRATION_CONTROL_CONTROL,
            `REG_CALIBRATION_CONTROL_CONFIG, `REG_CALIBRATION_CONTROL_STATE, `REG_INT_ENABLES,
            // R20 - factory offset registers writable
            `REG_FACT_OFFSET_MAG, `REG_FACT_OFFSET_SIGN: is_rw = 1'b1;
            default: is_rw = 1'b0;
        endcase
    end
endfunction

function [7:0] reset_val;
    input [7:0] a;
    begin
        case (a)
            `REG_PROX_SAMPLE_RATE: reset_val = `RST_PROX_SAMPLE_RATE;
            `REG_CONFIG_ZERO:      reset_val = `RST_CONFIG_ZERO;
            `REG_PROX_PULSE_CFG:   reset_val = `RST_PROX_PULSE_CFG;
            `REG_PROX_GAIN_CFG:    reset_val = `RST_PROX_GAIN_CFG;
            `REG_LIGHT_GAIN_CFG:   reset_val = `RST_LIGHT_GAIN_CFG;
            default:               reset_val = `RST_DEFAULT;
        endcase
    end
endfunction

reg  [7:0]  regs [0:127];
reg  [7:0]  ptr_q;
reg  [7:0]  hold_q;
reg  [7:0]  thr_lo_q;
reg         az_req_q;
reg  [6:0]  bus_q;
reg  [3:0]  bit_q;
reg  [7:0]  shift_q;
reg  [7:0]  tx_q;
reg         rd_mode_q;
reg         to_reg_q;
reg         scl_q;
reg         sda_q;
reg         scl_p;
reg         sda_p;
reg  [7:0]  rd_byte;
integer     i;

wire [7:0] en_r   = regs[A_EN[6:0]];
wire [7:0] at_r   = regs[A_AT[6:0]];
wire [7:0] pr_r   = regs[A_PR[6:0]];
wire [7:0] wt_r   = regs[A_WT[6:0]];
wire       wlong  = regs[A_C0[6:0]][`BIT_LONG_WAIT];
wire       rd_clr = regs[A_C3[6:0]][`BIT_READ_CLEAR];
wire       pon    = en_r[`BIT_POWER];

wire scl_rise = scl_q & ~scl_p;
wire scl_fall = ~scl_q & scl_p;
wire start_c  = scl_q & scl_p & sda_p & ~sda_q;
wire stop_c   = scl_q & scl_p & ~sda_p & sda_q;

// R19 - colour result map
always @* begin
    case (ptr_q)
        `REG_REVISION_CODE: rd_byte = REVISION_VALUE;
        `REG_PART_CODE:     rd_byte = PART_VALUE;
        `REG_DEVICE_FLAGS:  rd_byte = flags_q;
        `REG_CLEAR_LO:      rd_byte = clear_data[7:0];
        `REG_RED_LO:        rd_byte = red_data[7:0];
        `REG_GREEN_LO:      rd_byte = green_data[7:0];
        `REG_BLUE_LO:       rd_byte = blue_data[7:0];
        // R4 - high byte from latch
        `REG_CLEAR_HI, `REG_RED_HI, `REG_GREEN_HI, `REG_BLUE_HI: rd_byte = hold_q;
        `REG_PROX_RESULT:   rd_byte = prox_data;
        default:            rd_byte = (ptr_q[7] && is_rw(ptr_q)) ? regs[ptr_q[6:0]] : 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Two-wire slave and register file

always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
        // R22 - defaults and pointer cleared
        for (i = 0; i < 128; i = i + 1) begin
            regs[i] <= reset_val(8'h80 | i[7:0]);
        end
        ptr_q      <= 8'h00;
        hold_q     <= 8'h00;
        thr_lo_q   <= 8'h00;
        az_req_q   <= 1'b0;
        flags_q    <= 8'h00;
        bus_q      <= B_IDLE;
        bit_q      <= 4'h0;
        shift_q    <= 8'h00;
        tx_q       <= 8'h00;
        rd_mode_q  <= 1'b0;
        to_reg_q   <= 1'b0;
        scl_q      <= 1'b1;
        sda_q      <= 1'b1;
        scl_p      <= 1'b1;
        sda_p      <= 1'b1;
        sda_out_q  <= 1'b0;
        sda_oe_n_q <= 1'b1;
    end else begin
        scl_q    <= scl_in;
        sda_q    <= sda_in;
        scl_p    <= scl_q;
        sda_p    <= sda_q;
        az_req_q <= 1'b0;
        // R18 - hardware set beats clear
        flags_q  <= flags_q | {flag_set, 3'b000};
        if (start_c) begin
            bus_q      <= B_ADDR;
            bit_q      <= 4'h0;
            sda_oe_n_q <= 1'b1;
        end else if (stop_c) begin
            // R3 - pointer kept across stop
            bus_q      <= B_IDLE;
            sda_oe_n_q <= 1'b1;
        end else begin
            case (bus_q)
                B_IDLE: begin
                    sda_oe_n_q <= 1'b1;
                end
                B_ADDR, B_REG, B_WDAT: begin
                    if (scl_rise && bit_q != 4'h8) begin
                        shift_q <= {shift_q[6:0], sda_q};
                        bit_q   <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        // Only the byte after the chip address is the pointer
                        to_reg_q <= (bus_q == B_ADDR);
                        // R6 - ack on ninth clock
                        sda_oe_n_q <= 1'b0;
                        bus_q      <= B_ACK;
                        if (bus_q == B_ADDR) begin
                            // R1 - match chip address
                            if (shift_q[7:1] != CHIP_ADDR) begin
                                sda_oe_n_q <= 1'b1;
                                bus_q      <= B_IDLE;
                            end
                            rd_mode_q <= shift_q[0];
                        end else if (bus_q == B_REG) begin
                            ptr_q     <= shift_q;
                            rd_mode_q <= 1'b0;
                        end else begin
                            // R2 - increment after write byte
                            ptr_q <= ptr_q + 8'h01;
                            if (ptr_q == `REG_DEVICE_FLAGS) begin
                                flags_q <= (flags_q & ~shift_q) | {flag_set, 3'b000};
                            end else if (ptr_q == A_LLLO || ptr_q == A_LHLO) begin
                                thr_lo_q <= shift_q;
                            end else if (ptr_q == `REG_LT_LOW_HI || ptr_q == `REG_LT_HIGH_HI) begin
                                regs[ptr_q[6:0]]        <= shift_q;
                                regs[ptr_q[6:0] - 7'h1] <= thr_lo_q;
                            end else if (is_rw(ptr_q)) begin
                                regs[ptr_q[6:0]] <= shift_q;
                            end
                            // R11 - same write arms autozero
                            if (ptr_q == A_EN && shift_q[`BIT_LIGHT_EN] && shift_q[`BIT_POWER]
                                && !en_r[`BIT_LIGHT_EN]) begin
                                az_req_q <= 1'b1;
                            end
                        end
                    end
                end
                B_ACK, B_RACK: begin
                    if (bus_q == B_RACK && scl_rise && sda_q) begin
                        // R7 - master nack ends read
                        bus_q <= B_IDLE;
                    end else if (scl_fall) begin
                        if (rd_mode_q) begin
                            tx_q       <= {rd_byte[6:0], 1'b0};
                            sda_oe_n_q <= rd_byte[7];
                            bit_q      <= 4'h1;
                            bus_q      <= B_RDAT;
                            ptr_q      <= ptr_q + 8'h01;
                            case (ptr_q)
                                `REG_CLEAR_LO: hold_q <= clear_data[15:8];
                                `REG_RED_LO:   hold_q <= red_data[15:8];
                                `REG_GREEN_LO: hold_q <= green_data[15:8];
                                `REG_BLUE_LO:  hold_q <= blue_data[15:8];
                                default:       hold_q <= hold_q;
                            endcase
                            // R18 - clear on read when enabled
                            if (ptr_q == `REG_DEVICE_FLAGS && rd_clr) begin
                                flags_q <= {flag_set, 3'b000};
                            end
                        end else begin
                            sda_oe_n_q <= 1'b1;
                            bus_q      <= to_reg_q ? B_REG : B_WDAT;
                        end
                    end
                end
                B_RDAT: begin
                    if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            sda_oe_n_q <= 1'b1;
                            bus_q      <= B_RACK;
                        end else begin
                            sda_oe_n_q <= tx_q[7];
                            tx_q       <= {tx_q[6:0], 1'b0};
                            bit_q      <= bit_q + 4'h1;
                        end
                    end
                end
                default: begin
                    bus_q <= B_IDLE;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Oscillator, integration clock and step ticks

reg  [6:0]  osc_acc_q;
reg         osc_tick_q;
reg  [3:0]  div11_q;
reg  [11:0] step_cnt_q;
reg  [9:0]  unit_cnt_q;
reg         restart_q;

wire int_tick  = osc_tick_q && div11_q == `INT_CLK_DIV - 4'd1;
wire step_tick = int_tick && step_cnt_q == STEP_INT_CYCLES - 12'd1;
wire unit_tick = osc_tick_q && unit_cnt_q == PROX_UNIT_OSC - 10'd1;

always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
        osc_acc_q  <= 7'd0;
        osc_tick_q <= 1'b0;
        div11_q    <= 4'd0;
        step_cnt_q <= 12'd0;
        unit_cnt_q <= 10'd0;
    end else if (!pon || restart_q) begin
        // R8 - oscillator stopped without power
        osc_acc_q  <= 7'd0;
        osc_tick_q <= 1'b0;
        div11_q    <= 4'd0;
        step_cnt_q <= 12'd0;
        unit_cnt_q <= 10'd0;
    end else begin
        // Eight oscillator ticks per hundred core cycles
        if (osc_acc_q + `OSC_INC >= `OSC_MOD) begin
            osc_acc_q  <= osc_acc_q + `OSC_INC - `OSC_MOD;
            osc_tick_q <= 1'b1;
        end else begin
            osc_acc_q  <= osc_acc_q + `OSC_INC;
            osc_tick_q <= 1'b0;
        end
        if (osc_tick_q) begin
            // R15 - divide by eleven
            div11_q    <= (div11_q == `INT_CLK_DIV - 4'd1) ? 4'd0 : div11_q + 4'd1;
            unit_cnt_q <= (unit_cnt_q == PROX_UNIT_OSC - 10'd1) ? 10'd0 : unit_cnt_q + 10'd1;
        end
        if (int_tick) begin
            // R15 - 2048 integration clocks per step
            step_cnt_q <= (step_cnt_q == STEP_INT_CYCLES - 12'd1) ? 12'd0 : step_cnt_q + 12'd1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Measurement sequencer

reg  [4:0] seq_q;
reg  [7:0] cnt_q;
reg  [3:0] mult_q;

always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
        seq_q          <= S_IDLE;
        cnt_q          <= 8'h00;
        mult_q         <= 4'd0;
        restart_q      <= 1'b0;
        autozero_q     <= 1'b0;
        osc_on_q       <= 1'b0;
        prox_active_q  <= 1'b0;
        light_active_q <= 1'b0;
        wait_active_q  <= 1'b0;
        prox_done_q    <= 1'b0;
        light_done_q   <= 1'b0;
        light_max_q    <= 16'h03ff;
    end else begin
        osc_on_q     <= pon;
        restart_q    <= 1'b0;
        prox_done_q  <= 1'b0;
        light_done_q <= 1'b0;
        // R14 - 1024 per step, saturating
        light_max_q  <= (at_r[7:6] != 2'b00) ? 16'hffff : {at_r[5:0], 10'h3ff};
        if (az_req_q) begin
            autozero_q <= 1'b1;
        end
        if (!pon) begin
            // R9 - functions idle without power
            seq_q <= S_IDLE;
        end else begin
            case (seq_q)
                S_IDLE: begin
                    restart_q <= 1'b1;
                    mult_q    <= 4'd0;
                    if (en_r[`BIT_PROX_EN]) begin
                        seq_q <= S_PROX;
                        cnt_q <= pr_r;
                    end else if (en_r[`BIT_LIGHT_EN]) begin
                        seq_q <= (autozero_q || az_req_q) ? S_AZ : S_ALS;
                        cnt_q <= at_r;
                    end
                end
                S_PROX: begin
                    // R16 - rate+1 units of 88us
                    if (unit_tick) begin
                        if (cnt_q == 8'h00) begin
                            prox_done_q <= 1'b1;
                            restart_q   <= 1'b1;
                            cnt_q       <= en_r[`BIT_LIGHT_EN] ? at_r : wt_r;
                            seq_q       <= en_r[`BIT_LIGHT_EN] ? (autozero_q ? S_AZ : S_ALS)
                                         : (en_r[`BIT_WAIT_EN] ? S_WAIT : S_IDLE);
                        end else begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                end
                S_AZ: begin
                    // R11 - autozero step first
                    if (step_tick) begin
                        autozero_q <= 1'b0;
                        seq_q      <= S_ALS;
                    end
                end
                S_ALS: begin
                    // R13 - down count to terminal zero
                    if (step_tick) begin
                        if (cnt_q == 8'h00) begin
                            light_done_q <= 1'b1;
                            cnt_q        <= wt_r;
                            // R10 - wait only when enabled
                            seq_q        <= en_r[`BIT_WAIT_EN] ? S_WAIT : S_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                end
                S_WAIT: begin
                    if (step_tick) begin
                        // R21 - long wait twelve steps each
                        if (wlong && mult_q != `LONG_WAIT_MULT - 4'd1) begin
                            mult_q <= mult_q + 4'd1;
                        end else begin
                            mult_q <= 4'd0;
                            // R17 - value+1 wait steps
                            if (cnt_q == 8'h00) begin
                                seq_q <= S_IDLE;
                            end else begin
                                cnt_q <= cnt_q - 8'h01;
                            end
                        end
                    end
                end
                default: begin
                    seq_q <= S_IDLE;
                end
            endcase
        end
        prox_active_q  <= pon && seq_q == S_PROX;
        light_active_q <= pon && (seq_q == S_ALS || seq_q == S_AZ);
        wait_active_q  <= pon && seq_q == S_WAIT;
    end
end

endmodule // sensor_host_regs_and_timers

// >>> sensor_defs.vh
// Register offsets, reset values and timing constants of the sensor host block
`ifndef SENSOR_DEFS_VH
`define SENSOR_DEFS_VH

`define CLK_PERIOD_NS        10
`define OSC_INC              7'd8
`define OSC_MOD              7'd100
`define INT_CLK_DIV          4'd11
`define STEP_INT_CYCLES      12'd2048
`define OSC_PERIOD_NS        125
`define PROX_UNIT_NS         88000
`define PROX_UNIT_OSC        10'd704
`define LONG_WAIT_MULT       4'd12

`define REG_FUNCTION_ENABLES 8'h80
`define REG_LIGHT_INT_TIME   8'h81
`define REG_PROX_SAMPLE_RATE 8'h82
`define REG_WAIT_TIME        8'h83
`define REG_LT_LOW_LO        8'h84
`define REG_LT_LOW_HI        8'h85
`define REG_LT_HIGH_LO       8'h86
`define REG_LT_HIGH_HI       8'h87
`define REG_PROX_LOW_THRESH  8'h88
`define REG_PROX_HIGH_THRESH 8'h8a
`define REG_INT_PERSISTENCE  8'h8c
`define REG_CONFIG_ZERO      8'h8d
`define REG_PROX_PULSE_CFG   8'h8e
`define REG_PROX_GAIN_CFG    8'h8f
`define REG_CONFIG_ONE       8'h90
`define REG_REVISION_CODE    8'h91
`define REG_PART_CODE        8'h92
`define REG_DEVICE_FLAGS     8'h93
`define REG_CLEAR_LO         8'h94
`define REG_CLEAR_HI         8'h95
`define REG_RED_LO           8'h96
`define REG_RED_HI           8'h97
`define REG_GREEN_LO         8'h98
`define REG_GREEN_HI         8'h99
`define REG_BLUE_LO          8'h9a
`define REG_BLUE_HI          8'h9b
`define REG_PROX_RESULT      8'h9c
`define REG_LIGHT_GAIN_CFG   8'h9f
`define REG_CONFIG_THREE     8'hab
`define REG_PROX_OFFSET_MAG  8'hc0
`define REG_PROX_OFFSET_SIGN 8'hc1
`define REG_CALIBRATION_CONTROL_CONTROL    8'hd7
`define REG_CALIBRATION_CONTROL_CONFIG     8'hd9
`define REG_CALIBRATION_CONTROL_STATE      8'hdc
`define REG_INT_ENABLES      8'hdd
`define REG_FACT_OFFSET_MAG  8'he6
`define REG_FACT_OFFSET_SIGN 8'he7

`define RST_PROX_SAMPLE_RATE 8'h1f
`define RST_CONFIG_ZERO      8'h80
`define RST_PROX_PULSE_CFG   8'h80
`define RST_PROX_GAIN_CFG    8'h80
`define RST_LIGHT_GAIN_CFG   8'h04
`define RST_DEFAULT          8'h00

`define BIT_POWER            0
`define BIT_LIGHT_EN         1
`define BIT_PROX_EN          2
`define BIT_WAIT_EN          3
`define BIT_LONG_WAIT        2
`define BIT_READ_CLEAR       7

`endif

// >>> sensor_host_chk.sv
// Port-level assertions for the sensor host register bank
`timescale 1ns/100ps
module sensor_host_chk (
    input wire        core_clk,
    input wire        sys_rst,
    input wire        scl_in,
    input wire        sda_out_q,
    input wire        sda_oe_n_q,
    input wire [4:0]  flag_set,
    input wire [7:0]  flags_q,
    input wire        osc_on_q,
    input wire        prox_active_q,
    input wire        light_active_q,
    input wire        prox_done_q,
    input wire        light_done_q,
    input wire [15:0] light_max_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_sda_pull_only: assert property (sda_out_q == 1'b0)
        else $error("data pin driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_n_q) |-> !scl_in)
        else $error("data pin changed while bus clock high");
    a_light_needs_power: assert property (light_active_q |-> osc_on_q || $past(osc_on_q))
        else $error("light active without power");
    a_prox_needs_power: assert property (prox_active_q |-> osc_on_q || $past(osc_on_q))
        else $error("proximity active without power");
    a_light_done_after: assert property (light_done_q |-> $past(light_active_q) || $past(light_active_q, 2))
        else $error("light done without integration");
    a_prox_done_after: assert property (prox_done_q |-> $past(prox_active_q) || $past(prox_active_q, 2))
        else $error("proximity done without sample");
    a_max_low_ones: assert property (light_max_q[9:0] == 10'h3ff)
        else $error("maximum count not a whole step");
    a_flag_set_wins: assert property (|flag_set |=> (flags_q[7:3] & $past(flag_set)) == $past(flag_set))
        else $error("flag set pulse lost");
endmodule // sensor_host_chk

// >>> i2c_host_model.sv
// Two-wire bus master model with open-drain data
`timescale 1ns/100ps
module i2c_host_model (
    input  wire clk,
    input  wire sda,
    output reg  scl = 1'b1,
    output reg  sda_drv_n = 1'b1
);
    task hp;
        repeat (12) @(negedge clk);
    endtask
    task start;
        sda_drv_n = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda_drv_n = 1'b0;
        hp;
        scl = 1'b0;
        hp;
    endtask
    task stop;
        sda_drv_n = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda_drv_n = 1'b1;
        hp;
    endtask
    task bit_io(input b, output s);
        sda_drv_n = b;
        hp;
        scl = 1'b1;
        hp;
        s = sda;
        hp;
        scl = 1'b0;
        hp;
    endtask
    // ninth bit: released on writes, master ack or nack on reads
    task byte_io(input [7:0] d, input b9, output [7:0] q, output a);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], q[i]);
        bit_io(b9, a);
    endtask
endmodule // i2c_host_model

// >>> tb_sensor_host_regs_and_timers.sv
// Self-checking bench for the sensor host register bank and timers
`timescale 1ns/100ps
module tb_sensor_host_regs_and_timers;
    localparam [6:0] chip = 7'h29;
    reg         core_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [15:0] clear_data = 16'h1234;
    reg  [15:0] red_data = 16'hc3a5;
    reg  [4:0]  flag_set = 5'h00;
    reg  [15:0] v;
    reg  [7:0]  q;
    reg         k;
    integer     n_mismatch = 0;
    integer     n_tests = 0;
    wire        scl;
    wire        sda_drv_n;
    wire        sda_oe_n_q;
    wire        sda = sda_drv_n & sda_oe_n_q;
    wire        osc_on_q;
    wire        autozero_q;
    wire [2:0]  act;
    wire [7:0]  flags_q;
    wire [15:0] light_max_q;
    sensor_host_regs_and_timers #(.CHIP_ADDR(chip), .STEP_INT_CYCLES(12'd4), .PROX_UNIT_OSC(10'd4)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out_q(), .sda_oe_n_q(sda_oe_n_q),
        .clear_data(clear_data), .red_data(red_data), .green_data(16'h0f0f), .blue_data(16'h8001),
        .prox_data(8'h6e), .flag_set(flag_set), .flags_q(flags_q), .osc_on_q(osc_on_q), .autozero_q(autozero_q),
        .prox_active_q(act[0]), .light_active_q(act[1]), .wait_active_q(act[2]), .prox_done_q(), .light_done_q(),
        .light_max_q(light_max_q));
    i2c_host_model m (.clk(core_clk), .sda(sda), .scl(scl), .sda_drv_n(sda_drv_n));
    initial forever #5 core_clk = ~core_clk;
    task report_and_stop;
        $display("mismatches %0d of %0d compares", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tx(input [7:0] d);
        m.byte_io(d, 1'b1, q, k);
        chk(k, 1'b0);
    endtask
    task wr(input [7:0] p, input [15:0] d, input integer n);
        integer i;
        m.start;
        tx({chip, 1'b0});
        tx(p);
        for (i = 0; i < n; i = i + 1)
            tx(d[8*i+:8]);
        m.stop;
    endtask
    // optional pointer, repeated start, nack on last byte
    task rd(input [7:0] p, input setp, input integer n, output [15:0] d);
        integer i;
        d = 16'h0000;
        if (setp) begin
            m.start;
            tx({chip, 1'b0});
            tx(p);
        end
        m.start;
        tx({chip, 1'b1});
        for (i = 0; i < n; i = i + 1)
            m.byte_io(8'hff, i == n - 1, d[8*i+:8], k);
        m.stop;
    endtask
    // Skips a phase in progress, then times the next whole one
    task dur(input integer w, input integer exp);
        integer n;
        for (n = 0; act[w] === 1'b1 && n < 9000; n = n + 1) @(negedge core_clk);
        for (n = 0; act[w] !== 1'b1 && n < 9000; n = n + 1) @(negedge core_clk);
        for (n = 0; act[w] === 1'b1 && n < 9000; n = n + 1) @(negedge core_clk);
        if (n >= 9000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop;
        end
        chk(n > exp - 30 && n < exp + 30, 1'b1);
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        rd(8'h82, 1'b1, 1, v); chk(v, 16'h001f);
        rd(8'h8d, 1'b1, 2, v); chk(v, 16'h8080);
        rd(8'h9f, 1'b1, 1, v); chk(v, 16'h0004);
        wr(8'h83, 16'h005a, 1);
        rd(8'h82, 1'b1, 1, v); chk(v, 16'h001f);
        rd(8'h00, 1'b0, 1, v); chk(v, 16'h005a);
        rd(8'h94, 1'b1, 1, v); chk(v, 16'h0034);
        clear_data = 16'h5678;
        rd(8'h00, 1'b0, 1, v); chk(v, 16'h0012);
        rd(8'h96, 1'b1, 2, v); chk(v, 16'hc3a5);
        wr(8'h84, 16'hbeef, 2);
        rd(8'h84, 1'b1, 2, v); chk(v, 16'hbeef);
        wr(8'h86, 16'h0011, 1);
        rd(8'h86, 1'b1, 2, v); chk(v, 16'h0000);
        wr(8'h87, 16'h0022, 1);
        rd(8'h86, 1'b1, 2, v); chk(v, 16'h2211);
        m.start;
        m.byte_io({7'h2a, 1'b0}, 1'b1, q, k);
        m.stop;
        chk(k, 1'b1);
        flag_set = 5'h1f;
        @(negedge core_clk);
        flag_set = 5'h00;
        rd(8'h93, 1'b1, 1, v); chk(v, 16'h00f8);
        wr(8'h93, 16'h0080, 1);
        rd(8'h93, 1'b1, 1, v); chk(v, 16'h0078);
        wr(8'hab, 16'h0080, 1);
        rd(8'h93, 1'b1, 1, v); chk(v, 16'h0078);
        rd(8'h93, 1'b1, 1, v); chk(v, 16'h0000);
        wr(8'h81, 16'h003f, 1); chk(light_max_q, 16'hffff);
        wr(8'h81, 16'h0001, 1); chk(light_max_q, 16'h07ff);
        wr(8'h82, 16'h0001, 1);
        wr(8'h83, 16'h0000, 1);
        wr(8'he6, 16'h0155, 2);
        rd(8'he6, 1'b1, 2, v); chk(v, 16'h0155);
        wr(8'h80, 16'h0002, 1); chk(act, 3'b000);
        chk(osc_on_q, 1'b0);
        wr(8'h80, 16'h0000, 1);
        // light enable and power in one write
        wr(8'h80, 16'h0007, 1); chk(autozero_q, 1'b1);
        chk(osc_on_q, 1'b1);
        // Autozero step, then two integration steps
        dur(1, 1650);
        dur(0, 100);
        wr(8'h80, 16'h000f, 1);
        dur(2, 550);
        wr(8'h8d, 16'h0084, 1);
        dur(2, 6600);
        wr(8'h80, 16'h0000, 1); chk(osc_on_q, 1'b0);
        report_and_stop;
    end
endmodule // tb_sensor_host_regs_and_timers
bind sensor_host_regs_and_timers sensor_host_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in),
    .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q), .flag_set(flag_set), .flags_q(flags_q), .osc_on_q(osc_on_q),
    .prox_active_q(prox_active_q), .light_active_q(light_active_q), .prox_done_q(prox_done_q),
    .light_done_q(light_done_q), .light_max_q(light_max_q));
